// ==== common/iprc_regs.svh ====
// iprc_regs.svh: offsets, field positions, reset values and counts
// of the interrupt priority block; included by its design files
`ifndef IPRC_REGS_SVH
`define IPRC_REGS_SVH
// ----------------------------------------------------------------
// register indices on the plain register port
// ----------------------------------------------------------------
`define IPRC_A_PRIO_BASE 4'h0
`define IPRC_A_STATUS    4'h4
`define IPRC_A_CTRL1     4'h5
`define IPRC_A_SRL       4'h6
`define IPRC_A_PEND      4'h7
`define IPRC_A_ENAB      4'h8
// ----------------------------------------------------------------
// priority registers: implemented bits and reset values
// ----------------------------------------------------------------
`define IPRC_M_PRIO0 16'h0770
`define IPRC_M_PRIO1 16'h0770
`define IPRC_M_PRIO2 16'h7770
`define IPRC_M_PRIO3 16'h0777
`define IPRC_R_PRIO0 16'h0440
`define IPRC_R_PRIO1 16'h0440
`define IPRC_R_PRIO2 16'h4440
`define IPRC_R_PRIO3 16'h0444
`define IPRC_F_TOP 12
`define IPRC_F_HI  8
`define IPRC_F_MID 4
`define IPRC_F_LO  0
// ----------------------------------------------------------------
// control, status low byte, levels, vectors, sizes
// ----------------------------------------------------------------
`define IPRC_B_NEST_DIS 15
`define IPRC_B_TRAP0    0
`define IPRC_B_TRAP1    1
`define IPRC_M_CTRL1    16'h8003
`define IPRC_SRL_LVL    1
`define IPRC_TRAP0_LVL  4'hC
`define IPRC_TRAP1_LVL  4'hE
`define IPRC_MASK_MAX   4'h7
`define IPRC_TIMED_DISABLE_INSTR_MAX   4'h6
`define IPRC_VEC_BASE   7'h20
`define IPRC_VEC_TRAP0  7'h02
`define IPRC_VEC_TRAP1  7'h03
`define IPRC_NSRC       10
`define IPRC_NENT       12
`define IPRC_STK_DEPTH  4'h8
`endif

// ==== common/iprc_pkg.sv ====
// iprc_pkg: types shared by the interrupt priority block
// assumes iprc_regs.svh is included by each user file
package iprc_pkg;
   typedef logic [3:0] iprc_level_t;
   typedef logic [6:0] iprc_vec_t;
   // context saved on each taken interrupt
   typedef struct packed {
      logic [15:0] pc;
      logic [7:0]  status_low_byte;
      iprc_level_t level;
   } iprc_frame_s;
   // registered arbitration result
   typedef struct packed {
      logic        valid;
      iprc_level_t level;
      iprc_vec_t   vec;
   } iprc_take_s;
   typedef enum logic {IPRC_ST_RUN, IPRC_ST_SETTLE} iprc_state_e;
endpackage

// ==== rtl/iprc_arbiter.sv ====
// iprc_arbiter: picks the highest candidate level, lowest index on ties
// assumes a level of zero marks an ineligible candidate
`timescale 1ns/1ns
`include "iprc_regs.svh"
module iprc_arbiter
   import iprc_pkg::*;
(
   // candidates
   input  iprc_level_t [`IPRC_NENT-1:0] cand_level,
   // winner
   output logic [3:0]                   win_index,
   output iprc_level_t                  win_level,
   output logic                         win_valid
);
   always_comb begin
      win_index = 4'h0;
      win_level = 4'h0;
      for (int i = 0; i < `IPRC_NENT; i++) begin
         // strict compare keeps the lower index on a tie
         if (cand_level[i] > win_level) begin
            win_level = cand_level[i];
            win_index = 4'(i);
         end
      end
      win_valid = win_level != 4'h0;
   end
endmodule

// ==== rtl/iprc_frame_stack.sv ====
// iprc_frame_stack: small context stack for nested interrupts
// assumes push and pop never arrive in the same cycle
`timescale 1ns/1ns
`include "iprc_regs.svh"
module iprc_frame_stack
   import iprc_pkg::*;
(
   // clock and reset
   input  logic        core_clk,
   input  logic        reset_n,
   // stack operations
   input  logic        push,
   input  logic        pop,
   input  iprc_frame_s push_frame,
   output iprc_frame_s top_frame,
   output logic        empty,
   output logic        full
);
   iprc_frame_s mem [8];
   logic [3:0]  ptr_r;

   assign empty = ptr_r == 4'h0;
   assign full = ptr_r == `IPRC_STK_DEPTH;
   assign top_frame = empty ? '0 : mem[3'(ptr_r - 4'h1)];

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ptr_r <= 4'h0;
      end else if (pop && !empty) begin
         ptr_r <= ptr_r - 4'h1;
      end else if (push && !full) begin
         ptr_r <= ptr_r + 4'h1;
      end
   end

   // storage needs no reset; empty masks stale entries
   always_ff @(posedge core_clk) begin
      if (push && !full && !pop) begin
         mem[ptr_r[2:0]] <= push_frame;
      end
   end
endmodule

// ==== rtl/iprc_core.sv ====
// iprc_core: interrupt priority control, level tracking and context
// assumes the core acks only while irq_req is high, same clock domain
//
// How it works
// - field 111 is level 7, 000 disables
// - every priority field resets to level 4
// - unimplemented bits ignore writes, read zero
// - serial error fields at 10:8 and 6:4
// - dma7 at 6:4, dma6 at 2:0
// - status shows cpu level and vector
// - nesting disable bit 15 blocks user nesting, traps still nest
// - pending flag left set retakes interrupt
// - return restores pc, status byte, level
// - trap flag sticky until software clears
// - status byte level 7 masks users
// - traps at levels 12 and 14 masked only at cpu level >= own
// - timed disable masks levels 1 to 6
// - timed disable never blocks level 7
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
`include "iprc_regs.svh"
module iprc_core
   import iprc_pkg::*;
(
   // clock and reset
   input  logic                  core_clk,
   input  logic                  reset_n,
   // register port
   input  logic [3:0]            reg_addr,
   input  logic [15:0]           reg_wdata,
   input  logic                  reg_wr,
   input  logic                  reg_rd,
   output logic [15:0]           reg_rdata,
   // source and trap events
   input  logic [`IPRC_NSRC-1:0] src_event,
   input  logic [1:0]            trap_event,
   // interrupt request to the core
   output logic                  irq_req,
   output iprc_level_t           irq_level,
   output iprc_vec_t             irq_vector,
   input  logic                  irq_ack,
   input  logic [15:0]           ack_pc,
   // return from interrupt
   input  logic                  ret_req,
   output logic                  ret_valid,
   output logic [15:0]           ret_pc,
   // timed disable
   input  logic                  timed_disable_instr_start,
   input  logic [13:0]           timed_disable_instr_count,
   output logic                  timed_disable_instr_active
);
   localparam logic [15:0] PRIO_MASK [4] = '{`IPRC_M_PRIO0, `IPRC_M_PRIO1,
                                              `IPRC_M_PRIO2, `IPRC_M_PRIO3};
   localparam logic [15:0] PRIO_RST [4] = '{`IPRC_R_PRIO0, `IPRC_R_PRIO1,
                                             `IPRC_R_PRIO2, `IPRC_R_PRIO3};

   logic [15:0]                   prio_r [4];
   logic [3:0][15:0]              prio_all;
   logic                          nest_dis_r;
   logic [1:0]                    trap_r;
   logic [7:0]                    srl_r;
   logic [7:0]                    srl_view;
   iprc_level_t                   cpu_level_r;
   logic [`IPRC_NSRC-1:0]         pend_r;
   logic [`IPRC_NSRC-1:0]         enab_r;
   logic [13:0]                   timed_disable_instr_cnt_r;
   iprc_take_s                    best_r;
   logic [3:0]                    best_idx_r;
   iprc_state_e                   state_r;
   iprc_level_t [`IPRC_NENT-1:0]  cand;
   logic [3:0]                    win_idx;
   iprc_level_t                   win_lvl;
   logic                          win_valid;
   iprc_frame_s                   push_frame;
   iprc_frame_s                   top_frame;
   logic                          stk_empty;
   logic                          stk_full;
   logic                          take;
   logic                          ret;
   logic                          srl_wr;
   logic                          settle_ev;

   // ----------------------------------------------------------------
   // field decode
   // ----------------------------------------------------------------
   function automatic logic [2:0] src_prio(input logic [3:0][15:0] pr,
                                           input int idx);
      case (idx)
         0: src_prio = pr[0][`IPRC_F_HI +: 3];
         1: src_prio = pr[0][`IPRC_F_MID +: 3];
         2: src_prio = pr[1][`IPRC_F_HI +: 3];
         3: src_prio = pr[1][`IPRC_F_MID +: 3];
         4: src_prio = pr[2][`IPRC_F_TOP +: 3];
         5: src_prio = pr[2][`IPRC_F_HI +: 3];
         6: src_prio = pr[2][`IPRC_F_MID +: 3];
         7: src_prio = pr[3][`IPRC_F_HI +: 3];
         8: src_prio = pr[3][`IPRC_F_MID +: 3];
         9: src_prio = pr[3][`IPRC_F_LO +: 3];
         default: src_prio = 3'h0;
      endcase
   endfunction

   function automatic iprc_vec_t ent_vec(input logic [3:0] idx);
      if (idx == 4'(`IPRC_NSRC)) begin
         ent_vec = `IPRC_VEC_TRAP0;
      end else if (idx == 4'(`IPRC_NSRC + 1)) begin
         ent_vec = `IPRC_VEC_TRAP1;
      end else begin
         ent_vec = `IPRC_VEC_BASE + {3'h0, idx};
      end
   endfunction

   assign prio_all = {prio_r[3], prio_r[2], prio_r[1], prio_r[0]};
   assign srl_view = {srl_r[7:4], cpu_level_r[2:0], srl_r[0]};
   assign timed_disable_instr_active = timed_disable_instr_cnt_r != 14'h0;
   assign irq_req = best_r.valid && state_r == IPRC_ST_RUN && !stk_full;
   assign irq_level = best_r.level;
   assign irq_vector = best_r.vec;
   assign take = irq_ack && irq_req && !ret_req;
   assign ret = ret_req && !stk_empty;
   assign srl_wr = reg_wr && reg_addr == `IPRC_A_SRL;
   // anything that moves the level makes the registered winner stale
   assign settle_ev = take || ret || srl_wr || timed_disable_instr_start;
   assign push_frame = '{pc: ack_pc, status_low_byte: srl_view, level: cpu_level_r};

   // ----------------------------------------------------------------
   // priority registers
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_prio
      always_ff @(posedge core_clk) begin
         if (!reset_n) begin
            prio_r[g] <= PRIO_RST[g];
         end else if (reg_wr && reg_addr == `IPRC_A_PRIO_BASE + 4'(g)) begin
            prio_r[g] <= reg_wdata & PRIO_MASK[g];
         end
      end
   end

   // ----------------------------------------------------------------
   // control, pending and enable registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         nest_dis_r <= 1'b0;
         trap_r <= 2'h0;
      end else begin
         if (reg_wr && reg_addr == `IPRC_A_CTRL1) begin
            nest_dis_r <= reg_wdata[`IPRC_B_NEST_DIS];
         end
         // software may only clear; a new trap wins the same cycle
         if (reg_wr && reg_addr == `IPRC_A_CTRL1) begin
            trap_r <= (trap_r & reg_wdata[`IPRC_B_TRAP1:`IPRC_B_TRAP0]) | trap_event;
         end else begin
            trap_r <= trap_r | trap_event;
         end
      end
   end

   // hardware never clears a flag: a flag left set is taken again
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pend_r <= '0;
      end else if (reg_wr && reg_addr == `IPRC_A_PEND) begin
         pend_r <= reg_wdata[`IPRC_NSRC-1:0] | src_event;
      end else begin
         pend_r <= pend_r | src_event;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         enab_r <= '0;
      end else if (reg_wr && reg_addr == `IPRC_A_ENAB) begin
         enab_r <= reg_wdata[`IPRC_NSRC-1:0];
      end
   end

   // ----------------------------------------------------------------
   // timed disable
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         timed_disable_instr_cnt_r <= 14'h0;
      end else if (timed_disable_instr_start) begin
         timed_disable_instr_cnt_r <= timed_disable_instr_count;
      end else if (timed_disable_instr_active) begin
         timed_disable_instr_cnt_r <= timed_disable_instr_cnt_r - 14'h1;
      end
   end

   // ----------------------------------------------------------------
   // candidates and arbitration
   // ----------------------------------------------------------------
   for (genvar i = 0; i < `IPRC_NSRC; i++) begin : g_src
      logic [2:0] p;
      logic       ok;
      assign p = src_prio(prio_all, i);
      // level 7 passes the timed disable
      assign ok = enab_r[i] && pend_r[i] && p != 3'h0 && {1'b0, p} > cpu_level_r
                  && !(timed_disable_instr_active && {1'b0, p} <= `IPRC_TIMED_DISABLE_INSTR_MAX);
      assign cand[i] = ok ? {1'b0, p} : 4'h0;
   end

   // traps sit above every maskable level
   assign cand[`IPRC_NSRC] = (trap_r[0] && `IPRC_TRAP0_LVL > cpu_level_r) ?
                             `IPRC_TRAP0_LVL : 4'h0;
   assign cand[`IPRC_NSRC+1] = (trap_r[1] && `IPRC_TRAP1_LVL > cpu_level_r) ?
                               `IPRC_TRAP1_LVL : 4'h0;

   iprc_arbiter u_arb (
      .cand_level (cand),
      .win_index  (win_idx),
      .win_level  (win_lvl),
      .win_valid  (win_valid)
   );

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         best_r <= '0;
         best_idx_r <= 4'h0;
      end else begin
         best_r <= '{valid: win_valid, level: win_lvl,
                     vec: win_valid ? ent_vec(win_idx) : 7'h00};
         best_idx_r <= win_idx;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_r <= IPRC_ST_RUN;
      end else begin
         case (state_r)
            IPRC_ST_RUN: begin
               if (settle_ev) begin
                  state_r <= IPRC_ST_SETTLE;
               end
            end
            IPRC_ST_SETTLE: begin
               if (!settle_ev) begin
                  state_r <= IPRC_ST_RUN;
               end
            end
            default: state_r <= IPRC_ST_RUN;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // cpu level, status byte and context stack
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cpu_level_r <= 4'h0;
         srl_r <= 8'h00;
      end else if (ret) begin
         cpu_level_r <= top_frame.level;
         srl_r <= top_frame.status_low_byte;
      end else if (take) begin
         if (best_r.level > `IPRC_MASK_MAX || !nest_dis_r) begin
            cpu_level_r <= best_r.level;
         end else begin
            cpu_level_r <= `IPRC_MASK_MAX;
         end
      end else if (srl_wr) begin
         // or-ing 0x0E lifts the level to 7; a trap level keeps bit 3
         srl_r <= reg_wdata[7:0];
         cpu_level_r <= {cpu_level_r[3], reg_wdata[`IPRC_SRL_LVL +: 3]};
      end
   end

   iprc_frame_stack u_stack (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .push       (take),
      .pop        (ret),
      .push_frame (push_frame),
      .top_frame  (top_frame),
      .empty      (stk_empty),
      .full       (stk_full)
   );

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ret_valid <= 1'b0;
         ret_pc <= 16'h0000;
      end else begin
         ret_valid <= ret;
         if (ret) begin
            ret_pc <= top_frame.pc;
         end
      end
   end

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            4'h0, 4'h1, 4'h2, 4'h3: reg_rdata <= prio_r[reg_addr[1:0]];
            `IPRC_A_STATUS: reg_rdata <= {4'h0, cpu_level_r, 1'b0, best_r.vec};
            `IPRC_A_CTRL1: reg_rdata <= {nest_dis_r, 13'h0000, trap_r};
            `IPRC_A_SRL: reg_rdata <= {8'h00, srl_view};
            `IPRC_A_PEND: reg_rdata <= {6'h00, pend_r};
            `IPRC_A_ENAB: reg_rdata <= {6'h00, enab_r};
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_prio_reset: assert property (@(posedge core_clk)
      !reset_n |=> prio_r[2] == 16'h4440 && prio_r[3] == 16'h0444)
      else $error("priority fields not preset to level 4");

   chk_unimp_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_rd && reg_addr == 4'h3 |=> (reg_rdata & 16'hF888) == 16'h0000)
      else $error("unimplemented priority bits read nonzero");

   chk_zero_disables: assert property (@(posedge core_clk) disable iff (!reset_n)
      best_r.valid && best_idx_r < 4'hA |-> best_r.level != 4'h0 && best_r.level <= 4'h7)
      else $error("disabled or out of range source won");

   chk_strict_level: assert property (@(posedge core_clk) disable iff (!reset_n)
      irq_req |-> irq_level > cpu_level_r)
      else $error("request not above cpu level");

   chk_timed_disable_instr_mask: assert property (@(posedge core_clk) disable iff (!reset_n)
      irq_req && timed_disable_instr_active |-> irq_level >= 4'h7)
      else $error("timed disable let a low level through");

   chk_trap_unmask: assert property (@(posedge core_clk) disable iff (!reset_n)
      trap_r[1] && cpu_level_r < 4'hE && !settle_ev && !(reg_wr && reg_addr == 4'h5)
      |=> best_r.valid && best_r.level == 4'hE)
      else $error("trap was masked");

   chk_ret_restore: assert property (@(posedge core_clk) disable iff (!reset_n)
      ret |=> ret_valid && cpu_level_r == $past(top_frame.level) && ret_pc == $past(top_frame.pc))
      else $error("return did not restore context");

   chk_nest_level: assert property (@(posedge core_clk) disable iff (!reset_n)
      take && nest_dis_r && best_r.level <= 4'h7 |=> cpu_level_r == 4'h7 ##1 !irq_req)
      else $error("nesting disable did not raise level");

   chk_trap_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
      trap_r[0] && !(reg_wr && reg_addr == 4'h5) |=> trap_r[0])
      else $error("trap flag dropped without software clear");

   chk_status_map: assert property (@(posedge core_clk) disable iff (!reset_n)
      reg_rd && reg_addr == 4'h4 |=> reg_rdata[11:8] == $past(cpu_level_r))
      else $error("status register level mismatch");

   chk_srl_mask: assert property (@(posedge core_clk) disable iff (!reset_n)
      srl_wr && !take && !ret && reg_wdata[3:1] == 3'h7 && !cpu_level_r[3]
      |=> cpu_level_r == 4'h7)
      else $error("status byte write did not mask user levels");
endmodule

// ==== tb/iprc_core_partner.sv ====
// iprc_core_partner: behavioural processor core that takes and returns interrupts
// assumes the block's request is settled at each rising edge of the same clock
`timescale 1ns/1ns
module iprc_core_partner (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // service control from the bench
   input  wire logic        svc_en,
   input  wire logic [3:0]  svc_cycles,
   // interrupt handshake
   input  wire logic        irq_req,
   output logic             irq_ack,
   output logic [15:0]      ack_pc,
   output logic             ret_req
);
   logic [3:0]  depth_r;
   logic [3:0]  cnt_r;
   logic [15:0] pc_r;
   always_ff @(posedge core_clk) begin
      irq_ack <= 1'b0;
      ret_req <= 1'b0;
      // pc means nothing away from the ack, so never leave it stable
      ack_pc  <= ~ack_pc;
      if (!reset_n) begin
         depth_r <= 4'h0;
         cnt_r   <= 4'h0;
         pc_r    <= 16'h1000;
         ack_pc  <= 16'h0000;
      end else if (irq_req && svc_en && !irq_ack && !ret_req) begin
         irq_ack <= 1'b1;
         ack_pc  <= pc_r;
         pc_r    <= pc_r + 16'h0104;
         depth_r <= depth_r + 4'h1;
         cnt_r   <= svc_cycles;
      end else if (depth_r != 4'h0) begin
         if (cnt_r == 4'h0) begin
            ret_req <= 1'b1;
            depth_r <= depth_r - 4'h1;
            cnt_r   <= svc_cycles;
         end else begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule

// ==== tb/iprc_core_tb.sv ====
// iprc_core_tb: self-checking bench for the interrupt priority block
// assumes the partner core acks and returns on its own once enabled
`timescale 1ns/1ns
module iprc_core_tb;
   logic        core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        timed_disable_instr_start = 1'b0, svc_en = 1'b0, rd_flag = 1'b0;
   logic        irq_req, irq_ack, ret_req, ret_valid, timed_disable_instr_active;
   logic [3:0]  reg_addr = 4'h0, svc_cycles = 4'h8, irq_level;
   logic [6:0]  irq_vector;
   logic [9:0]  src_event = 10'h000;
   logic [1:0]  trap_event = 2'h0;
   logic [13:0] timed_disable_instr_count = 14'h0000;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, ack_pc, ret_pc, wv, ev;
   logic [15:0] rd_q[$], take_q[$], pc_q[$];
   logic [15:0] rst_v [4] = '{16'h0440, 16'h0440, 16'h4440, 16'h0444};
   logic [15:0] msk_v [4] = '{16'h0770, 16'h0770, 16'h7770, 16'h0777};
   integer      fail_count = 0, samples_checked = 0, seed = 36, i;

   always #5 core_clk = ~core_clk;

   iprc_core i_iprc_core (
      .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
      .trap_event(trap_event), .irq_req(irq_req), .irq_level(irq_level),
      .irq_vector(irq_vector), .irq_ack(irq_ack), .ack_pc(ack_pc), .ret_req(ret_req),
      .ret_valid(ret_valid), .ret_pc(ret_pc), .timed_disable_instr_start(timed_disable_instr_start),
      .timed_disable_instr_count(timed_disable_instr_count), .timed_disable_instr_active(timed_disable_instr_active));
   iprc_core_partner i_iprc_core_partner (
      .core_clk(core_clk), .reset_n(reset_n), .svc_en(svc_en), .svc_cycles(svc_cycles),
      .irq_req(irq_req), .irq_ack(irq_ack), .ack_pc(ack_pc), .ret_req(ret_req));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic give_up(input integer n);
      fail_count++;
      $display("ERROR at %0t: waited %h cycles, expected below %h", $time, n, 300);
      end_of_test();
   endtask
   // one idle cycle after each strobe keeps a strobe from being set twice in a step
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      rd_q.push_back(e);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic pulse(input logic [9:0] s, input logic [1:0] t, input logic d);
      src_event  <= s;
      trap_event <= t;
      timed_disable_instr_start <= d;
      @(posedge core_clk);
      src_event  <= 10'h000;
      trap_event <= 2'h0;
      timed_disable_instr_start <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wait_ack;
      integer n;
      n = 0;
      do begin
         @(negedge core_clk);
         n++;
      end while (!(irq_ack === 1'b1 && irq_req === 1'b1) && n < 300);
      if (irq_ack !== 1'b1 || irq_req !== 1'b1) begin
         give_up(n);
      end
      @(posedge core_clk);
   endtask
   task automatic wait_idle;
      integer n;
      n = 0;
      while ((take_q.size() != 0 || pc_q.size() != 0) && n < 300) begin
         @(posedge core_clk);
         n++;
      end
      if (take_q.size() != 0 || pc_q.size() != 0) begin
         give_up(n);
      end
      repeat (4) @(posedge core_clk);
   endtask

   // ----------------------------------------------------------------
   // watcher: takes the oldest read and take note, the newest pc, whenever a result shows
   // ----------------------------------------------------------------
   always @(negedge core_clk) begin
      if (rd_flag) begin
         check(reg_rdata, rd_q.pop_front());
      end
      rd_flag = reg_rd;
      if (ret_valid === 1'b1) begin
         check(ret_pc, (pc_q.size() > 0) ? pc_q.pop_back() : 16'hFFFF);
      end
      if (irq_ack === 1'b1 && irq_req === 1'b1) begin
         ev = (take_q.size() > 0) ? take_q.pop_front() : 16'hFFFF;
         check({4'(pc_q.size()), irq_level, 1'b0, irq_vector}, ev);
         check({15'h0000, timed_disable_instr_active & (irq_level < 4'h7)}, 16'h0000);
         pc_q.push_back(ack_pc);
      end
   end

   initial begin
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      for (i = 0; i < 16; i++) begin
         rd(i[3:0], (i < 4) ? rst_v[i] : 16'h0000);
      end
      for (i = 0; i < 4; i++) begin
         wv = $random(seed);
         wr(i[3:0], wv);
         rd(i[3:0], wv & msk_v[i]);
      end
      wr(4'h4, 16'hFFFF);
      wr(4'h9, 16'hFFFF);
      rd(4'h4, 16'h0000);
      rd(4'h9, 16'h0000);
      // nesting: dma4 at 3, parallel port at 5 on top, rtc disabled
      wr(4'h0, 16'h0350);
      wr(4'h1, 16'h0000);
      wr(4'h7, 16'h0000);
      wr(4'h8, 16'h0007);
      pulse(10'h005, 2'h0, 1'b0);
      rd(4'h4, 16'h0020);
      take_q = '{16'h0320, 16'h1521, 16'h0320};
      svc_en <= 1'b1;
      wait_ack();
      pulse(10'h002, 2'h0, 1'b0);
      wait_ack();
      wr(4'h7, 16'h0001);
      wait_ack();
      wr(4'h7, 16'h0000);
      wait_idle();
      // nesting disabled: the higher source waits for the return
      wr(4'h5, 16'h8000);
      take_q = '{16'h0320, 16'h0521};
      pulse(10'h001, 2'h0, 1'b0);
      wait_ack();
      pulse(10'h002, 2'h0, 1'b0);
      wr(4'h7, 16'h0002);
      wait_ack();
      wr(4'h7, 16'h0000);
      wr(4'h5, 16'h0000);
      wait_idle();
      // level 7 masks users, traps still enter
      svc_cycles <= 4'h2;
      wr(4'h3, 16'h0070);
      wr(4'h8, 16'h0101);
      wr(4'h6, 16'h000E);
      pulse(10'h101, 2'h0, 1'b0);
      repeat (8) @(posedge core_clk);
      take_q = '{16'h0E03, 16'h0C02};
      pulse(10'h000, 2'h3, 1'b0);
      wait_ack();
      wr(4'h5, 16'h0001);
      wait_ack();
      wr(4'h5, 16'h0000);
      wait_idle();
      // timed disable: level 7 passes, level 3 waits for expiry
      svc_cycles <= 4'h8;
      take_q = '{16'h0728, 16'h0320};
      timed_disable_instr_count <= 14'h0028;
      pulse(10'h000, 2'h0, 1'b1);
      wr(4'h6, 16'h0000);
      wait_ack();
      check({15'h0000, timed_disable_instr_active}, 16'h0001);
      wr(4'h7, 16'h0001);
      wait_ack();
      wr(4'h7, 16'h0000);
      wait_idle();
      // flat setup: every enabled source at one level, lower index first
      take_q = '{16'h0420, 16'h0421};
      wr(4'h0, 16'h0440);
      wr(4'h8, 16'h0003);
      pulse(10'h003, 2'h0, 1'b0);
      wait_ack();
      wr(4'h7, 16'h0002);
      wait_ack();
      wr(4'h7, 16'h0000);
      wait_idle();
      end_of_test();
   end
endmodule
